// >>> include/mpo_params.svh
`ifndef MPO_PARAMS_SVH
`define MPO_PARAMS_SVH

// ==========================================================
// Register map
`define MPO_ADDR_CTRL 12'h000
`define MPO_ADDR_PERIOD 12'h004
`define MPO_ADDR_DUTY 12'h008
`define MPO_ADDR_STATUS 12'h00c
`define MPO_ADDR_SYNC 12'h010

// ==========================================================
// Field positions
`define MPO_CTRL_EN_BIT 0
`define MPO_ST_RUN_BIT 0
`define MPO_ST_LOCK_BIT 1
`define MPO_ST_POL_BIT 2
`define MPO_ST_TRI_BIT 3
`define MPO_ST_NPH_LSB 4

// ==========================================================
// Reset values and minimum period
`define MPO_CTRL_RST 1'b0
`define MPO_PERIOD_RST 16'h00fa
`define MPO_DUTY_RST 16'h007d
`define MPO_PERIOD_MIN 16'h0004

`endif

// >>> include/mpo_pkg.sv
package mpo_pkg;

    typedef enum logic [1:0] {
        ST_POR = 2'b01,
        ST_RUN = 2'b10
    } mpo_state_t;

    typedef logic [15:0] mpo_count_t;

endpackage : mpo_pkg

// >>> include/mpo_phase_if.sv
interface mpo_phase_if;
    mpo_pkg::mpo_count_t cnt;
    mpo_pkg::mpo_count_t period;
    mpo_pkg::mpo_count_t duty;

    modport drv (output cnt, output period, output duty);
    modport gen (input cnt, input period, input duty);
endinterface : mpo_phase_if

// >>> core/mpo_phase_gen.sv
module mpo_phase_gen (
    mpo_phase_if.gen bus,
    input wire logic [15:0] offset,
    output logic pulse
);
    logic [16:0] pos;

    // ==========================================================
    // Position within the period, measured from this phase's start.
    always_comb
    begin
        if (bus.cnt >= offset)
        begin
            pos = {1'b0, bus.cnt} - {1'b0, offset};
        end
        else
        begin
            pos = {1'b0, bus.cnt} + {1'b0, bus.period} - {1'b0, offset};
        end
        pulse = (pos < {1'b0, bus.duty});
    end
endmodule : mpo_phase_gen

// >>> core/mpo_top.sv
`include "mpo_params.svh"
module mpo_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic output_polarity_select,
    input wire logic tri_level_select,
    input wire logic sync_in,
    input wire logic supply_above_rise,
    input wire logic supply_above_fall,
    output logic phase_out_1,
    output logic phase_out_2,
    output logic phase_out_3_o,
    input wire logic phase_out_3_i,
    output logic phase_out_3_oe_n,
    output logic phase_out_4_o,
    input wire logic phase_out_4_i,
    output logic phase_out_4_oe_n,
    output logic [3:0] phase_mid_level,
    output logic clk_out,
    output logic drive_enable
);
    mpo_pkg::mpo_state_t state_ff;
    logic pol_ff, tri_ff, en_ff, lock_ff, sync_d_ff;
    logic [2:0] nph_ff;
    logic [15:0] period_ff, duty_ff, cnt_ff, meas_ff, sync_per_ff;
    logic [15:0] eff_period, step;
    logic [3:0] raw, active;
    logic [15:0] offs [4];
    logic [3:0] pin_ff;
    logic clk_out_ff, run, sync_rise, p1_pre_ff;
    logic wr, rd_setup;
    mpo_phase_if pif ();

    // ==========================================================
    // Power-on-reset with hysteresis.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            state_ff <= mpo_pkg::ST_POR;
        else
        begin
            case (state_ff)
                mpo_pkg::ST_POR:
                    if (supply_above_rise)
                        state_ff <= mpo_pkg::ST_RUN;
                mpo_pkg::ST_RUN:
                    if (!supply_above_fall)
                        state_ff <= mpo_pkg::ST_POR;
                default:
                    state_ff <= mpo_pkg::ST_POR;
            endcase
        end
    end
    assign run = (state_ff == mpo_pkg::ST_RUN) && en_ff;

    // ==========================================================
    // Strap capture. Phase 3/4 pins are released while in reset so the
    // board tie-ups can be read; afterwards the values are frozen.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pol_ff <= 1'b0;
            tri_ff <= 1'b0;
            nph_ff <= 3'h4;
        end
        else if (state_ff == mpo_pkg::ST_POR)
        begin
            pol_ff <= output_polarity_select;
            tri_ff <= tri_level_select;
            if (phase_out_3_i)
                nph_ff <= 3'h2;
            else if (phase_out_4_i)
                nph_ff <= 3'h3;
            else
                nph_ff <= 3'h4;
        end
    end

    // ==========================================================
    // APB slave, zero wait state access; read data prepared in setup.
    assign wr = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= rd_setup;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (rd_setup)
            begin
                case (paddr)
                    `MPO_ADDR_CTRL:
                        prdata <= {31'h0, en_ff};
                    `MPO_ADDR_PERIOD:
                        prdata <= {16'h0, period_ff};
                    `MPO_ADDR_DUTY:
                        prdata <= {16'h0, duty_ff};
                    `MPO_ADDR_STATUS:
                        prdata <= {25'h0, nph_ff, tri_ff, pol_ff, lock_ff,
                            state_ff == mpo_pkg::ST_RUN};
                    `MPO_ADDR_SYNC:
                        prdata <= {16'h0, sync_per_ff};
                    default:
                        pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            en_ff <= `MPO_CTRL_RST;
            period_ff <= `MPO_PERIOD_RST;
            duty_ff <= `MPO_DUTY_RST;
        end
        else if (wr)
        begin
            if (paddr == `MPO_ADDR_CTRL)
                en_ff <= pwdata[`MPO_CTRL_EN_BIT];
            // Too short a period would make the phase step zero.
            if (paddr == `MPO_ADDR_PERIOD && pwdata[15:0] >= `MPO_PERIOD_MIN)
                period_ff <= pwdata[15:0];
            if (paddr == `MPO_ADDR_DUTY)
                duty_ff <= pwdata[15:0];
        end
    end

    // ==========================================================
    // Sync measurement. An input held low never locks, and a lost
    // sync drops back to the programmed period after two periods.
    assign sync_rise = sync_in && !sync_d_ff;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_d_ff <= 1'b0;
            meas_ff <= 16'h0000;
            sync_per_ff <= `MPO_PERIOD_RST;
            lock_ff <= 1'b0;
        end
        else
        begin
            sync_d_ff <= sync_in;
            if (sync_rise)
            begin
                meas_ff <= 16'h0001;
                if (meas_ff >= `MPO_PERIOD_MIN
                    && meas_ff <= {period_ff[14:0], 1'b0})
                begin
                    sync_per_ff <= meas_ff;
                    lock_ff <= 1'b1;
                end
            end
            else if (meas_ff > {period_ff[14:0], 1'b0})
                lock_ff <= 1'b0;
            else
                meas_ff <= meas_ff + 16'h0001;
        end
    end
    assign eff_period = lock_ff ? sync_per_ff : period_ff;

    // ==========================================================
    // Period counter; a sync edge while locked restarts phase 1.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            cnt_ff <= 16'h0000;
        else if (!run || (lock_ff && sync_rise)
            || cnt_ff >= eff_period - 16'h0001)
            cnt_ff <= 16'h0000;
        else
            cnt_ff <= cnt_ff + 16'h0001;
    end

    assign pif.cnt = cnt_ff;
    assign pif.period = eff_period;
    assign pif.duty = duty_ff;
    assign step = eff_period / {13'h0, nph_ff};

    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_phase
            assign offs[i] = 16'(step * i);
            assign active[i] = run && (i < nph_ff);
            mpo_phase_gen u_gen (
                .bus(pif),
                .offset(offs[i]),
                .pulse(raw[i])
            );
            always_ff @(posedge clk_sys or negedge nrst)
            begin
                if (!nrst)
                begin
                    pin_ff[i] <= 1'b0;
                    phase_mid_level[i] <= 1'b0;
                end
                else
                begin
                    pin_ff[i] <= (raw[i] && active[i]) ^ pol_ff;
                    phase_mid_level[i] <= tri_ff && !active[i];
                end
            end
        end
    endgenerate

    assign phase_out_1 = pin_ff[0];
    assign phase_out_2 = pin_ff[1];
    assign phase_out_3_o = pin_ff[2];
    assign phase_out_4_o = pin_ff[3];

    // ==========================================================
    // Pin enables, driver enable and clock output.
    // The clock only rises on a phase 1 leading edge, so a period change
    // or a sync restart cannot make a stray rising edge.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_out_3_oe_n <= 1'b1;
            phase_out_4_oe_n <= 1'b1;
            drive_enable <= 1'b0;
            clk_out_ff <= 1'b0;
            p1_pre_ff <= 1'b0;
        end
        else
        begin
            phase_out_3_oe_n <= !(run && nph_ff > 3'h2);
            phase_out_4_oe_n <= !(run && nph_ff > 3'h3);
            drive_enable <= run;
            p1_pre_ff <= raw[0] && active[0];
            if (raw[0] && active[0] && !p1_pre_ff)
                clk_out_ff <= 1'b1;
            else if (!run || cnt_ff >= {1'b0, eff_period[15:1]})
                clk_out_ff <= 1'b0;
        end
    end
    assign clk_out = clk_out_ff;

    // ==========================================================
    // Checks.
    chk_por_rise: assert property (@(posedge clk_sys)
        disable iff (!nrst) state_ff == mpo_pkg::ST_POR && supply_above_rise
        |=> state_ff == mpo_pkg::ST_RUN)
        else $error("no start above rising threshold");
    chk_por_fall: assert property (@(posedge clk_sys)
        disable iff (!nrst) state_ff == mpo_pkg::ST_RUN && !supply_above_fall
        |=> state_ff == mpo_pkg::ST_POR)
        else $error("no stop below falling threshold");
    chk_drive_en_run: assert property (@(posedge clk_sys)
        disable iff (!nrst) drive_enable == $past(run))
        else $error("driver enable not following run state");
    chk_straps_frozen: assert property (@(posedge clk_sys)
        disable iff (!nrst) $past(state_ff) == mpo_pkg::ST_RUN
        |-> $stable(pol_ff) && $stable(tri_ff) && $stable(nph_ff))
        else $error("strap value changed while running");
    chk_polarity_idle: assert property (@(posedge clk_sys)
        disable iff (!nrst) !run |=> phase_out_1 == $past(pol_ff))
        else $error("idle phase level ignores polarity");
    chk_two_phase: assert property (@(posedge clk_sys)
        disable iff (!nrst) nph_ff == 3'h2 |=> phase_out_3_o == $past(pol_ff)
        && phase_out_4_o == $past(pol_ff))
        else $error("dropped phase switching");
    chk_tri_mid: assert property (@(posedge clk_sys)
        disable iff (!nrst) phase_mid_level != 4'h0 |-> $past(tri_ff))
        else $error("mid level without tri-level strap");
    chk_clk_align: assert property (@(posedge clk_sys)
        disable iff (!nrst) $rose(clk_out) |-> $rose(phase_out_1 ^ pol_ff))
        else $error("clock out not aligned to phase 1");
    chk_sync_restart: assert property (@(posedge clk_sys)
        disable iff (!nrst) lock_ff && sync_rise |=> cnt_ff == 16'h0000)
        else $error("sync edge did not restart period");
endmodule : mpo_top

// >>> tb/mpo_drv_model.sv
// ==========
// Driver chips and board straps on the phase pins.
module mpo_drv_model (
    input wire logic pol,
    input wire logic drive_enable,
    input wire logic ph_1,
    input wire logic ph_2,
    input wire logic ph_3,
    input wire logic oe_3_n,
    input wire logic ph_4,
    input wire logic oe_4_n,
    input wire logic tie_3,
    input wire logic tie_4,
    output logic pin_3,
    output logic pin_4,
    output logic [3:0] gate_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // An undriven pin falls to the input pull-down unless tied high.
    assign pin_3 = !oe_3_n ? ph_3 : tie_3;
    assign pin_4 = !oe_4_n ? ph_4 : tie_4;
    assign gate_on = drive_enable ? {pin_4, pin_3, ph_2, ph_1} ^ {4{pol}}
        : 4'h0;
endmodule : mpo_drv_model

// >>> tb/mpo_tb.sv
module mpo_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} mpo_note_t;
    mpo_note_t q[$];
    mpo_note_t t;
    logic clk_sys = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pol = 1'h0, tri_s = 1'h0, s_rise = 1'h0;
    logic sync_in = 1'h0;
    logic s_fall = 1'h0, tie_3 = 1'h0, tie_4 = 1'h0, lead;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, st;
    logic pready, pslverr, p1, p2, p3o, p3i, p3n, p4o, p4i, p4n, clk_out;
    logic drive_enable;
    logic [3:0] mid, gate_on, c;
    logic [3:0] cfgs [3] = '{4'h2, 4'hd, 4'h8};
    int errors = 0, samples_checked = 0, per, act, pr, du, sp, nph, o2;
    mpo_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .output_polarity_select(pol), .tri_level_select(tri_s),
        .sync_in(sync_in), .supply_above_rise(s_rise),
        .supply_above_fall(s_fall), .phase_out_1(p1), .phase_out_2(p2),
        .phase_out_3_o(p3o), .phase_out_3_i(p3i), .phase_out_3_oe_n(p3n),
        .phase_out_4_o(p4o), .phase_out_4_i(p4i), .phase_out_4_oe_n(p4n),
        .phase_mid_level(mid), .clk_out(clk_out),
        .drive_enable(drive_enable));
    mpo_drv_model drv_u (.pol(pol), .drive_enable(drive_enable),
        .ph_1(p1), .ph_2(p2), .ph_3(p3o), .oe_3_n(p3n), .ph_4(p4o),
        .oe_4_n(p4n), .tie_3(tie_3), .tie_4(tie_4), .pin_3(p3i),
        .pin_4(p4i), .gate_on(gate_on));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // ==========
    // Bus master and result monitor.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic e);
        int n;
        q.push_back('{d, m, e});
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (n >= 20)
            chk(32'h0, 32'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask : apb

    always @(posedge clk_sys)
    begin
        if (psel && penable && pready === 1'h1 && q.size() > 0)
        begin
            t = q.pop_front();
            chk(prdata & t.m, t.d & t.m);
            chk({31'h0, pslverr}, {31'h0, t.e});
        end
    end

    // Period and active width of phase 1, taken between clk_out rises.
    task automatic meas();
        int t0;
        logic pc;
        logic pp;
        logic pq;
        per = 0;
        act = 0;
        o2 = -1;
        pq = p2;
        lead = 1'h1;
        t0 = -1;
        pc = clk_out;
        pp = p1;
        for (int n = 0; n < 600 && per == 0; n++)
        begin
            @(posedge clk_sys);
            if (clk_out === 1'h1 && pc === 1'h0)
            begin
                if (p1 !== ~pol || pp !== pol)
                    lead = 1'h0;
                if (t0 >= 0)
                    per = n - t0;
                else
                    t0 = n;
            end
            if (t0 >= 0 && per == 0 && p1 === ~pol)
                act++;
            if (t0 >= 0 && o2 < 0 && p2 === ~pol && pq === pol)
                o2 = n - t0;
            pq = p2;
            pc = clk_out;
            pp = p1;
        end
    endtask : meas

    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end

    // The whole run is well under 2000 cycles; the 25000-cycle limit leaves wide margin.
    initial
    begin
        #100000;
        errors++;
        wrap_up();
    end

    // ==========
    // Main sequence.
    initial
    begin
        void'($urandom(32'h9cf8089d));
        repeat (4) @(posedge clk_sys);
        nrst <= 1'h1;
        @(posedge clk_sys);
        chk({30'h0, p3n, p4n}, 32'h3);
        apb(1'h0, 12'h000, 32'h0, 32'h1, 1'h0);
        apb(1'h0, 12'h004, 32'hfa, 32'hffff, 1'h0);
        apb(1'h0, 12'h008, 32'h7d, 32'hffff, 1'h0);
        apb(1'h0, 12'h014, 32'h0, 32'hffffffff, 1'h1);
        $display("Test reset defaults done");
        foreach (cfgs[i])
        begin
            c = cfgs[i];
            nph = c[1] ? 2 : c[0] ? 3 : 4;
            st = {25'h0, nph[2:0], c[2], c[3], 2'h1};
            {pol, tri_s, tie_3, tie_4} <= c;
            s_fall <= 1'h0;
            s_rise <= 1'h0;
            repeat (3) @(posedge clk_sys);
            chk({30'h0, drive_enable, |gate_on}, 32'h0);
            s_fall <= 1'h1;
            repeat (3) @(posedge clk_sys);
            apb(1'h0, 12'h00c, 32'h0, 32'h1, 1'h0);
            s_rise <= 1'h1;
            repeat (3) @(posedge clk_sys);
            apb(1'h0, 12'h00c, st, 32'h7d, 1'h0);
            {pol, tri_s} <= ~c[3:2];
            apb(1'h0, 12'h00c, st, 32'h7d, 1'h0);
            {pol, tri_s} <= c[3:2];
            pr = 8 + $urandom % 33;
            du = 1 + $urandom % (pr - 1);
            apb(1'h1, 12'h004, pr, 32'h0, 1'h0);
            apb(1'h1, 12'h004, 32'h3, 32'h0, 1'h0);
            apb(1'h0, 12'h004, pr, 32'hffff, 1'h0);
            apb(1'h1, 12'h008, du, 32'h0, 1'h0);
            apb(1'h1, 12'h000, 32'h1, 32'h0, 1'h0);
            meas();
            chk(per, pr);
            chk(act, du);
            chk(o2, pr / nph);
            chk({31'h0, lead}, 32'h1);
            chk({31'h0, drive_enable}, 32'h1);
            chk({26'h0, mid, p3n, p4n}, {26'h0, c[2] & (nph < 4),
                c[2] & (nph < 3), 2'h0, nph < 3, nph < 4});
            $display("Test config %0d done", i);
        end
        sp = pr + 4;
        fork
            repeat (12)
            begin
                sync_in <= 1'h1;
                @(posedge clk_sys);
                sync_in <= 1'h0;
                repeat (sp - 1) @(posedge clk_sys);
            end
            begin
                repeat (3 * sp) @(posedge clk_sys);
                meas();
                chk(per, sp);
                chk(o2, sp / nph);
            end
        join
        apb(1'h0, 12'h00c, 32'h2, 32'h2, 1'h0);
        repeat (3 * pr) @(posedge clk_sys);
        apb(1'h0, 12'h00c, 32'h0, 32'h2, 1'h0);
        $display("Test sync done");
        s_rise <= 1'h0;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, drive_enable}, 32'h1);
        s_fall <= 1'h0;
        repeat (3) @(posedge clk_sys);
        chk({30'h0, drive_enable, |gate_on}, 32'h0);
        apb(1'h0, 12'h00c, 32'h0, 32'h1, 1'h0);
        $display("Test shutdown done");
        wrap_up();
    end
endmodule : mpo_tb
